// ---- pkg/rms_map.vh ----
`ifndef RMS_MAP_VH
`define RMS_MAP_VH

// Coprocessor-0 register number of the setup word
`define RMS_SETUP_REG_NUM 5'd3

// Setup word field positions
`define RMS_FREEZE_BIT 31
`define RMS_TURN_BIT 30
`define RMS_QUAD_BIT 29
`define RMS_FPSEL_HI 28
`define RMS_FPSEL_LO 26
`define RMS_HALT_BIT 25
`define RMS_RF_BIT 24
`define RMS_SPLIT_BIT 23

// Reset values of the fixed fields
`define RMS_FPSEL_RESET 3'h3
`define RMS_FREEZE_RESET 1'b0
`define RMS_SPLIT_RESET 1'b0
`define RMS_HALT_RESET 1'b0
`define RMS_RF_RESET 1'b0

// Mode vector pin positions
`define RMS_MODE_DMA 5
`define RMS_MODE_SINGLE 4
`define RMS_MODE_HALFBUS 3
`define RMS_MODE_REFILL 2
`define RMS_MODE_TRISTATE 1
`define RMS_MODE_BIGEND 0

// Clock ratios, in cycles of core_clk
`define RMS_DIV_SINGLE 5'd1
`define RMS_DIV_DOUBLE 5'd2
`define RMS_DIV_REDUCED 5'd16

// Bus turnaround gaps, in cycles of core_clk
`define RMS_TURN_NORMAL 3'd1
`define RMS_TURN_EXTENDED 3'd3

`endif

// ---- logic/rms_mode_capture.v ----
`timescale 1ns/1ps
`include "rms_map.vh"

module rms_mode_capture (
    input wire core_clk, // Clock
    input wire rst, // Synchronous reset, active high
    input wire ce, // Clock enable
    input wire [5:3] irq_line, // Interrupt pins 5..3, low selects mode
    input wire [2:0] sampled_irq_line, // Interrupt pins 2..0, low selects mode
    output reg coherent_dma_select, // Coherent DMA invalidation enabled
    output reg single_rate_clock_select, // Input clock at execution rate
    output reg half_bus_select, // Bus at half core rate
    output reg dcache_block_refill_select, // Reset-time quad refill
    output reg tristate_test_select, // Tri-state test mode
    output reg byte_order_high_first // Big-endian ordering
);

    // Levels are followed for the whole reset and frozen at release
    always @(posedge core_clk)
    begin
        if (ce && rst)
        begin
            coherent_dma_select <= ~irq_line[`RMS_MODE_DMA];
            single_rate_clock_select <= ~irq_line[`RMS_MODE_SINGLE];
            half_bus_select <= ~irq_line[`RMS_MODE_HALFBUS];
            dcache_block_refill_select <= ~sampled_irq_line[`RMS_MODE_REFILL];
            tristate_test_select <= ~sampled_irq_line[`RMS_MODE_TRISTATE];
            byte_order_high_first <= ~sampled_irq_line[`RMS_MODE_BIGEND];
        end
    end

endmodule // rms_mode_capture

// ---- logic/rms_clock_divider.v ----
`timescale 1ns/1ps
`include "rms_map.vh"

module rms_clock_divider (
    input wire core_clk, // Clock
    input wire rst, // Synchronous reset, active high
    input wire ce, // Clock enable
    input wire single_rate, // Input clock at execution rate
    input wire half_bus, // Bus at half core rate
    input wire reduced, // Divide execution by 16
    output reg core_tick, // One-cycle execution enable
    output reg bus_tick, // One-cycle bus enable
    output reg sys_clk_out // Output clock, toggles per bus tick
);

    reg [4:0] div_cnt_reg;
    reg bus_phase_reg;
    wire [4:0] base_div;
    wire [8:0] full_div;

    assign base_div = single_rate ? `RMS_DIV_SINGLE : `RMS_DIV_DOUBLE;
    // Longest ratio is 32, so the count still fits 5 bits
    assign full_div = reduced ? {4'h0, base_div} * {4'h0, `RMS_DIV_REDUCED} : {4'h0, base_div};

    always @(posedge core_clk)
    begin
        if (rst && ce)
        begin
            div_cnt_reg <= 5'h00;
            bus_phase_reg <= 1'b0;
            core_tick <= 1'b0;
            bus_tick <= 1'b0;
            sys_clk_out <= 1'b0;
        end
        else if (ce)
        begin
            if ({4'h0, div_cnt_reg} + 9'd1 >= full_div)
            begin
                div_cnt_reg <= 5'h00;
                core_tick <= 1'b1;
                bus_phase_reg <= half_bus ? ~bus_phase_reg : 1'b0;
                bus_tick <= ~half_bus | bus_phase_reg;
                if (~half_bus | bus_phase_reg)
                begin
                    sys_clk_out <= ~sys_clk_out;
                end
            end
            else
            begin
                div_cnt_reg <= div_cnt_reg + 5'h01;
                core_tick <= 1'b0;
                bus_tick <= 1'b0;
            end
        end
    end

endmodule // rms_clock_divider

// ---- logic/rms_setup_top.v ----
`timescale 1ns/1ps
`include "rms_map.vh"

module rms_setup_top (
    input wire core_clk, // Clock, 125 MHz
    input wire rst, // Synchronous reset, active high
    input wire ce, // Clock enable, low freezes state
    input wire [5:0] irq_line, // External interrupt pins, active low
    input wire fpu_irq, // Float unit interrupt request, active high
    input wire cop_wr_en, // Coprocessor store strobe
    input wire cop_rd_en, // Coprocessor load strobe
    input wire [4:0] cop_reg_num, // Coprocessor-0 register number
    input wire [31:0] cop_wr_data, // Store data
    input wire bus_read_done, // Memory finished driving read data
    input wire bus_write_req, // Processor wants to drive a write
    output reg [31:0] cop_rd_data, // Load data
    output reg cop_rd_valid, // Load data valid pulse
    output wire [5:0] core_irq, // Interrupts seen by core, active high
    output wire core_stall, // Halt stall to core
    output wire bus_write_ok, // Processor may drive the bus
    output wire dcache_quad_refill, // Data refill of 4 words
    output wire cache_split_even, // 8kB/8kB cache split
    output wire coherent_dma_select, // Reset mode: coherent DMA
    output wire byte_order_high_first, // Reset mode: big-endian
    output wire tristate_test_select, // Reset mode: tri-state test
    output wire core_tick, // Execution enable
    output wire bus_tick, // Bus interface enable
    output wire sys_clk_out // Output clock
);

    // Turnaround states, one-hot
    localparam ST_IDLE = 3'b001;
    localparam ST_GAP = 3'b010;
    localparam ST_OPEN = 3'b100;

    reg write_freeze_bit_reg;
    reg extended_turnaround_bit_reg;
    reg quad_refill_bit_reg;
    reg [2:0] fpu_irq_select_reg;
    reg stall_until_event_bit_reg;
    reg reduced_frequency_bit_reg;
    reg split_cache_bit_reg;
    reg [2:0] turn_state_reg;
    reg [2:0] turn_state_next;
    reg [2:0] gap_cnt_reg;
    reg [2:0] gap_cnt_next;
    wire single_rate_clock_select;
    wire half_bus_select;
    wire dcache_block_refill_select;
    wire setup_hit_wr;
    wire setup_hit_rd;
    wire any_irq;
    wire [2:0] gap_len;
    wire [5:0] fpu_mask;
    wire [31:0] setup_word;

    // Next values of the setup word fields
    reg write_freeze_bit_next;
    reg extended_turnaround_bit_next;
    reg quad_refill_bit_next;
    reg [2:0] fpu_irq_select_next;
    reg stall_until_event_bit_next;
    reg reduced_frequency_bit_next;
    reg split_cache_bit_next;

    function setup_hit;
        input strobe;
        input [4:0] num;
        begin
            setup_hit = strobe & (num == `RMS_SETUP_REG_NUM);
        end
    endfunction

    // Binary input number; weight 2**n in the interrupt field
    function [5:0] route_mask;
        input [2:0] sel;
        begin
            route_mask = (sel < 3'h6) ? (6'h01 << sel) : 6'h00;
        end
    endfunction

    function [31:0] pack_word;
        input lock;
        input turn;
        input quad;
        input [2:0] fpsel;
        input halt;
        input rf;
        input split;
        begin
            pack_word = 32'h0000_0000;
            pack_word[`RMS_FREEZE_BIT] = lock;
            pack_word[`RMS_TURN_BIT] = turn;
            pack_word[`RMS_QUAD_BIT] = quad;
            pack_word[`RMS_FPSEL_HI:`RMS_FPSEL_LO] = fpsel;
            pack_word[`RMS_HALT_BIT] = halt;
            pack_word[`RMS_RF_BIT] = rf;
            pack_word[`RMS_SPLIT_BIT] = split;
        end
    endfunction

    // Low pin levels during reset select the modes
    rms_mode_capture u_capture (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .irq_line(irq_line[5:3]),
        .sampled_irq_line(irq_line[2:0]),
        .coherent_dma_select(coherent_dma_select),
        .single_rate_clock_select(single_rate_clock_select),
        .half_bus_select(half_bus_select),
        .dcache_block_refill_select(dcache_block_refill_select),
        .tristate_test_select(tristate_test_select),
        .byte_order_high_first(byte_order_high_first)
    );

    // Reduced frequency slows execution and output clock alike
    rms_clock_divider u_divider (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .single_rate(single_rate_clock_select),
        .half_bus(half_bus_select),
        .reduced(reduced_frequency_bit_reg),
        .core_tick(core_tick),
        .bus_tick(bus_tick),
        .sys_clk_out(sys_clk_out)
    );

    assign setup_hit_wr = setup_hit(cop_wr_en, cop_reg_num);
    assign setup_hit_rd = setup_hit(cop_rd_en, cop_reg_num);

    // Assigned pin is masked and replaced by the float unit request
    assign fpu_mask = route_mask(fpu_irq_select_reg);
    assign core_irq = (~irq_line & ~fpu_mask)
        | (fpu_mask & {6{fpu_irq}});
    assign any_irq = |core_irq;
    assign core_stall = stall_until_event_bit_reg & ~any_irq;
    assign dcache_quad_refill = quad_refill_bit_reg;
    assign cache_split_even = split_cache_bit_reg;

    // Next setup word: software stores, hardware clears the halt bit
    always @*
    begin
        write_freeze_bit_next = write_freeze_bit_reg;
        extended_turnaround_bit_next = extended_turnaround_bit_reg;
        quad_refill_bit_next = quad_refill_bit_reg;
        fpu_irq_select_next = fpu_irq_select_reg;
        stall_until_event_bit_next = stall_until_event_bit_reg;
        reduced_frequency_bit_next = reduced_frequency_bit_reg;
        split_cache_bit_next = split_cache_bit_reg;
        if (setup_hit_wr && !write_freeze_bit_reg)
        begin
            write_freeze_bit_next = cop_wr_data[`RMS_FREEZE_BIT];
            extended_turnaround_bit_next = cop_wr_data[`RMS_TURN_BIT];
            quad_refill_bit_next = cop_wr_data[`RMS_QUAD_BIT];
            fpu_irq_select_next = cop_wr_data[`RMS_FPSEL_HI:`RMS_FPSEL_LO];
            reduced_frequency_bit_next = cop_wr_data[`RMS_RF_BIT];
            split_cache_bit_next = cop_wr_data[`RMS_SPLIT_BIT];
            // A pending interrupt wins over a store that sets halt
            stall_until_event_bit_next = cop_wr_data[`RMS_HALT_BIT] & ~any_irq;
        end
        else if (any_irq)
        begin
            stall_until_event_bit_next = 1'b0;
        end
    end

    // Reset waits for the clock enable like every other flip-flop
    always @(posedge core_clk)
    begin
        if (rst && ce)
        begin
            write_freeze_bit_reg <= `RMS_FREEZE_RESET;
            fpu_irq_select_reg <= `RMS_FPSEL_RESET;
            split_cache_bit_reg <= `RMS_SPLIT_RESET;
            stall_until_event_bit_reg <= `RMS_HALT_RESET;
            reduced_frequency_bit_reg <= `RMS_RF_RESET;
            quad_refill_bit_reg <= ~irq_line[`RMS_MODE_REFILL];
            extended_turnaround_bit_reg <= ~irq_line[`RMS_MODE_HALFBUS];
        end
        else if (ce)
        begin
            write_freeze_bit_reg <= write_freeze_bit_next;
            extended_turnaround_bit_reg <= extended_turnaround_bit_next;
            quad_refill_bit_reg <= quad_refill_bit_next;
            fpu_irq_select_reg <= fpu_irq_select_next;
            stall_until_event_bit_reg <= stall_until_event_bit_next;
            reduced_frequency_bit_reg <= reduced_frequency_bit_next;
            split_cache_bit_reg <= split_cache_bit_next;
        end
    end

    // Word image with reserved bits forced to zero
    assign setup_word = pack_word(write_freeze_bit_reg, extended_turnaround_bit_reg,
        quad_refill_bit_reg, fpu_irq_select_reg, stall_until_event_bit_reg,
        reduced_frequency_bit_reg, split_cache_bit_reg);

    // Loads answer one cycle later; other registers read as zero
    always @(posedge core_clk)
    begin
        if (rst && ce)
        begin
            cop_rd_data <= 32'h0000_0000;
            cop_rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            cop_rd_valid <= cop_rd_en;
            if (setup_hit_rd)
            begin
                cop_rd_data <= setup_word;
            end
            else if (cop_rd_en)
            begin
                cop_rd_data <= 32'h0000_0000;
            end
        end
    end

    // Gap between memory releasing read data and a processor write
    assign gap_len = extended_turnaround_bit_reg ? `RMS_TURN_EXTENDED : `RMS_TURN_NORMAL;
    assign bus_write_ok = turn_state_reg != ST_GAP;

    always @*
    begin
        turn_state_next = turn_state_reg;
        gap_cnt_next = gap_cnt_reg;
        case (turn_state_reg)
            ST_IDLE:
            begin
                if (bus_read_done)
                begin
                    turn_state_next = ST_GAP;
                    gap_cnt_next = gap_len;
                end
            end
            ST_GAP:
            begin
                if (gap_cnt_reg <= 3'h1)
                begin
                    turn_state_next = ST_OPEN;
                    gap_cnt_next = 3'h0;
                end
                else
                begin
                    gap_cnt_next = gap_cnt_reg - 3'h1;
                end
            end
            ST_OPEN:
            begin
                if (bus_read_done)
                begin
                    turn_state_next = ST_GAP;
                    gap_cnt_next = gap_len;
                end
                else if (!bus_write_req)
                begin
                    turn_state_next = ST_IDLE;
                end
            end
            default:
            begin
                turn_state_next = ST_IDLE;
                gap_cnt_next = 3'h0;
            end
        endcase
    end

    always @(posedge core_clk)
    begin
        if (rst && ce)
        begin
            turn_state_reg <= ST_IDLE;
            gap_cnt_reg <= 3'h0;
        end
        else if (ce)
        begin
            turn_state_reg <= turn_state_next;
            gap_cnt_reg <= gap_cnt_next;
        end
    end

endmodule // rms_setup_top

// ---- bench/rms_board_mux.sv ----
`timescale 1ns/1ps

module rms_board_mux (
    input wire logic rst, // Board reset
    input wire logic [5:0] mode_on, // Modes wanted, 1 = on
    input wire logic [5:0] periph_irq, // Peripheral requests, 1 = asserted
    output wire logic [5:0] irq_line // Interrupt pins, active low
);
    // Unwanted modes stay high during reset, which leaves them off
    assign irq_line = rst ? ~mode_on : ~periph_irq;
endmodule // rms_board_mux

// ---- bench/rms_setup_properties.sv ----
`timescale 1ns/1ps

module rms_setup_props (
    input logic core_clk, // Clock
    input logic rst, // Reset
    input logic ce, // Enable
    input logic [5:0] irq_line, // Pins
    input logic fpu_irq, // Float request
    input logic cop_wr_en, // Store
    input logic cop_rd_en, // Load
    input logic [4:0] cop_reg_num, // Register number
    input logic [31:0] cop_wr_data, // Store data
    input logic bus_read_done, // Read end
    input logic [31:0] cop_rd_data, // Load data
    input logic cop_rd_valid, // Load valid
    input logic [5:0] core_irq, // Core interrupts
    input logic core_stall, // Halt stall
    input logic bus_write_ok, // Write allowed
    input logic dcache_quad_refill, // Quad refill
    input logic cache_split_even, // Even split
    input logic coherent_dma_select, // Mode
    input logic byte_order_high_first, // Mode
    input logic tristate_test_select // Mode
);
    logic lock_sh;
    logic turn_sh;
    logic [2:0] fpsel_sh;
    wire wr3 = ce && cop_wr_en && cop_reg_num == 5'h03;
    // Codes 6 and 7 route nowhere, so every pin passes
    wire [5:0] exp_irq = (fpsel_sh > 3'h5) ? ~irq_line :
        ((~irq_line & ~(6'h01 << fpsel_sh)) | ({5'h00, fpu_irq} << fpsel_sh));

    always @(posedge core_clk)
    begin
        if (rst && ce)
        begin
            lock_sh <= 1'b0;
            turn_sh <= ~irq_line[3];
            fpsel_sh <= 3'h3;
        end
        else if (wr3 && !lock_sh)
        begin
            lock_sh <= cop_wr_data[31];
            turn_sh <= cop_wr_data[30];
            fpsel_sh <= cop_wr_data[28:26];
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_reset_modes: assert property ($fell(rst) && $past(ce) |->
        coherent_dma_select == !$past(irq_line[5]) && tristate_test_select == !$past(irq_line[1]) &&
        byte_order_high_first == !$past(irq_line[0]) && dcache_quad_refill == !$past(irq_line[2]) && !cache_split_even)
        else $error("reset values wrong");
    a_load_valid: assert property (ce && cop_rd_en |=> cop_rd_valid) else $error("load valid missing");
    a_valid_cause: assert property (cop_rd_valid |-> $past(cop_rd_en)) else $error("stray load valid");
    a_unmapped_zero: assert property (ce && cop_rd_en && cop_reg_num != 5'h03 |=> cop_rd_data == 32'h0)
        else $error("unmapped load not zero");
    a_write_fields: assert property (wr3 && !lock_sh |=> dcache_quad_refill == $past(cop_wr_data[29]) &&
        cache_split_even == $past(cop_wr_data[23])) else $error("fields not stored");
    a_word_readback: assert property ((wr3 && !lock_sh) ##1 !cop_wr_en ##1 (cop_rd_en && wr3 == 1'b0 &&
        ce && cop_reg_num == 5'h03) |=> cop_rd_data[31:26] == $past(cop_wr_data[31:26], 3) &&
        cop_rd_data[24:0] == {$past(cop_wr_data[24:23], 3), 23'h0}) else $error("read back wrong");
    a_frozen_hold: assert property (wr3 && lock_sh |=> $stable(dcache_quad_refill) && $stable(cache_split_even))
        else $error("frozen word changed");
    a_irq_route: assert property (core_irq == exp_irq) else $error("interrupt routing wrong");
    a_stall_no_irq: assert property (core_stall |-> core_irq == 6'h00) else $error("stall with interrupt");
    a_halt_stalls: assert property ((wr3 && !lock_sh && cop_wr_data[25] && core_irq == 6'h00) ##1
        core_irq == 6'h00 |-> core_stall) else $error("halt did not stall");
    a_turn_normal: assert property (ce && bus_read_done && !turn_sh |=> !bus_write_ok ##1
        (bus_write_ok || $past(bus_read_done))) else $error("normal gap wrong");
    a_turn_extended: assert property (ce && bus_read_done && turn_sh |=> !bus_write_ok [*3])
        else $error("extended gap short");

    c_frozen_write: cover property (wr3 && lock_sh);
    c_extended_gap: cover property (ce && bus_read_done && turn_sh);
    c_halted: cover property (core_stall);
endmodule // rms_setup_props

bind rms_setup_top rms_setup_props rms_setup_props_inst (.core_clk(core_clk), .rst(rst), .ce(ce), .irq_line(irq_line),
    .fpu_irq(fpu_irq), .cop_wr_en(cop_wr_en), .cop_rd_en(cop_rd_en), .cop_reg_num(cop_reg_num),
    .cop_wr_data(cop_wr_data), .bus_read_done(bus_read_done), .cop_rd_data(cop_rd_data), .cop_rd_valid(cop_rd_valid),
    .core_irq(core_irq), .core_stall(core_stall), .bus_write_ok(bus_write_ok), .dcache_quad_refill(dcache_quad_refill),
    .cache_split_even(cache_split_even), .coherent_dma_select(coherent_dma_select),
    .byte_order_high_first(byte_order_high_first), .tristate_test_select(tristate_test_select));

// ---- bench/tb.sv ----
`timescale 1ns/1ps

module tb;
    logic core_clk = 0, rst = 1, ce = 1, fpu_irq = 0, wr = 0, rd = 0, done = 0, wreq = 1;
    logic [4:0] num = 5'h03;
    logic [31:0] wdata = 32'h0;
    logic [5:0] mode_on = 6'h00, periph = 6'h00;
    wire [5:0] irq_line, core_irq;
    wire [31:0] rdata;
    wire rvalid, stall, wok, quad, split, dma, bige, tri_s, ctick, btick, sclk;
    int error_cnt = 0, num_checks = 0, cyc = 0;

    rms_board_mux rms_board_mux_inst (.rst(rst), .mode_on(mode_on), .periph_irq(periph), .irq_line(irq_line));
    rms_setup_top rms_setup_top_inst (.core_clk(core_clk), .rst(rst), .ce(ce), .irq_line(irq_line), .fpu_irq(fpu_irq),
        .cop_wr_en(wr), .cop_rd_en(rd), .cop_reg_num(num), .cop_wr_data(wdata), .bus_read_done(done),
        .bus_write_req(wreq), .cop_rd_data(rdata), .cop_rd_valid(rvalid), .core_irq(core_irq), .core_stall(stall),
        .bus_write_ok(wok), .dcache_quad_refill(quad), .cache_split_even(split), .coherent_dma_select(dma),
        .byte_order_high_first(bige), .tristate_test_select(tri_s), .core_tick(ctick), .bus_tick(btick),
        .sys_clk_out(sclk));

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    // Whole run is under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_word(input logic [31:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        num <= 5'h03;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_word(input logic [4:0] n, input logic [31:0] exp);
        @(posedge core_clk);
        rd <= 1'b1;
        num <= n;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk("load valid", 32'h1, {31'h0, rvalid});
        chk("load data", exp, rdata);
    endtask

    task automatic do_reset(input logic [5:0] m);
        @(posedge core_clk);
        mode_on <= m;
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk("modes", {29'h0, m[5], m[1], m[0]}, {29'h0, dma, tri_s, bige});
        chk("reset refill", {31'h0, m[2]}, {31'h0, quad});
    endtask

    task automatic t_ticks(input int exp_c, input int exp_b);
        int c;
        int b;
        int t;
        logic p;
        c = 0;
        b = 0;
        t = 0;
        repeat (32) @(posedge core_clk);
        #1;
        p = sclk;
        repeat (128)
        begin
            @(posedge core_clk);
            #1;
            c += ctick;
            b += btick;
            t += int'(sclk !== p);
            p = sclk;
        end
        chk("core ticks", exp_c, c);
        chk("bus ticks", exp_b, b);
        chk("clock out toggles", exp_b, t);
    endtask

    task automatic t_fields;
        rd_word(5'h03, 32'h0c00_0000);
        wr_word(32'h2c80_0000);
        rd_word(5'h03, 32'h2c80_0000);
        chk("quad split", 32'h3, {30'h0, quad, split});
        rd_word(5'h05, 32'h0);
    endtask

    task automatic t_route;
        for (int s = 0; s < 6; s++)
        begin
            wr_word({3'h0, s[2:0], 26'h0});
            @(posedge core_clk);
            periph <= 6'h3f;
            fpu_irq <= 1'b0;
            #1;
            chk("irq pins", {26'h0, 6'h3f & ~(6'h01 << s)}, {26'h0, core_irq});
            @(posedge core_clk);
            periph <= 6'h00;
            fpu_irq <= 1'b1;
            #1;
            chk("irq float", {26'h0, 6'h01 << s}, {26'h0, core_irq});
        end
        @(posedge core_clk);
        fpu_irq <= 1'b0;
    endtask

    task automatic t_turn(input logic ext, input int exp);
        int n;
        n = 0;
        wr_word({1'b0, ext, 1'b0, 3'h3, 26'h0});
        @(posedge core_clk);
        done <= 1'b1;
        @(posedge core_clk);
        done <= 1'b0;
        #1;
        while (!wok && n < 8)
        begin
            n++;
            @(posedge core_clk);
            #1;
        end
        chk("turn gap", exp, n);
    endtask

    task automatic t_halt;
        wr_word(32'h0e00_0000);
        chk("stall set", 32'h1, {31'h0, stall});
        @(posedge core_clk);
        periph <= 6'h02;
        #1;
        chk("stall wake", 32'h0, {31'h0, stall});
        @(posedge core_clk);
        periph <= 6'h00;
        rd_word(5'h03, 32'h0c00_0000);
    endtask

    task automatic t_lock;
        wr_word(32'h8c00_0000);
        wr_word(32'h2080_0000);
        rd_word(5'h03, 32'h8c00_0000);
        chk("frozen fields", 32'h0, {30'h0, quad, split});
    endtask

    initial
    begin
        do_reset(6'h00);
        t_ticks(64, 64);
        t_fields();
        t_route();
        t_turn(1'b0, 1);
        t_turn(1'b1, 3);
        t_halt();
        t_lock();
        do_reset(6'h3f);
        rd_word(5'h03, 32'h6c00_0000);
        t_ticks(128, 64);
        wr_word(32'h6d00_0000);
        t_ticks(8, 4);
        summarize();
    end
endmodule // tb
